// file: hdl/iac_addsub.v
`timescale 1ns/1ns

// ********************************************
// Adder/subtractor with signed overflow and compares
// ********************************************
module iac_addsub #(
	parameter WIDTH = 32
) (
	// Operands
	input wire [WIDTH-1:0] a,
	input wire [WIDTH-1:0] b,
	input wire sub,
	// Results
	output wire [WIDTH-1:0] sum,
	output wire ovf,
	output wire lt_s,
	output wire lt_u
);
	wire [WIDTH-1:0] b_eff;
	wire [WIDTH:0] full;
	wire [WIDTH:0] diff_full;

	assign b_eff = sub ? ~b : b;
	assign full = {1'b0, a} + {1'b0, b_eff} + {{WIDTH{1'b0}}, sub};
	assign sum = full[WIDTH-1:0];
	// Overflow: operands of equal sign give a result of the other sign
	assign ovf = (a[WIDTH-1] == b_eff[WIDTH-1]) && (sum[WIDTH-1] != a[WIDTH-1]);
	// Compare uses its own subtraction so it never depends on sub
	assign diff_full = {1'b0, a} + {1'b0, ~b} + {{WIDTH{1'b0}}, 1'b1};
	assign lt_u = ~diff_full[WIDTH];
	assign lt_s = (a[WIDTH-1] != b[WIDTH-1]) ? a[WIDTH-1] : diff_full[WIDTH-1];
endmodule

// file: hdl/iac_map.vh
`ifndef IAC_MAP_VH
`define IAC_MAP_VH

// ********************************************
// Operation codes presented by the decoder
// ********************************************
`define IAC_OP_W 4
`define IAC_OP_SUM_IMM_TRAP 4'h0
`define IAC_OP_SUM_IMM_WRAP 4'h1
`define IAC_OP_SLT_IMM_S 4'h2
`define IAC_OP_SLT_IMM_U 4'h3
`define IAC_OP_AND_IMM 4'h4
`define IAC_OP_OR_IMM 4'h5
`define IAC_OP_XOR_IMM 4'h6
`define IAC_OP_UPPER_IMM 4'h7
`define IAC_OP_SUM_TRAP 4'h8
`define IAC_OP_SUM_WRAP 4'h9
`define IAC_OP_DIFF_TRAP 4'hA
`define IAC_OP_DIFF_WRAP 4'hB
`define IAC_OP_SLT_S 4'hC
`define IAC_OP_SLT_U 4'hD
`define IAC_OP_AND 4'hE
`define IAC_OP_NOR_OR_XOR 4'hF

// ********************************************
// Register-form logic sub-select (for op 4'hF)
// ********************************************
`define IAC_LSEL_OR 2'h0
`define IAC_LSEL_XOR 2'h1
`define IAC_LSEL_NOR 2'h2

// ********************************************
// Field layout and reset values
// ********************************************
`define IAC_IMM_W 16
`define IAC_IMM_MSB 15
`define IAC_DEST_W 5
`define IAC_RESULT_RST 32'h0000_0000

`endif

// file: hdl/iac_opnd.v
`timescale 1ns/1ns
`include "iac_map.vh"

// ********************************************
// Second operand selection and immediate extension
// ********************************************
module iac_opnd #(
	parameter WIDTH = 32
) (
	// Inputs
	input wire use_imm,
	input wire sign_ext,
	input wire upper,
	input wire [`IAC_IMM_W-1:0] imm,
	input wire [WIDTH-1:0] src_b,
	// Output
	output wire [WIDTH-1:0] opnd_b
);
	wire [WIDTH-1:0] imm_sx;
	wire [WIDTH-1:0] imm_zx;
	wire [WIDTH-1:0] imm_up;

	assign imm_sx = {{(WIDTH-`IAC_IMM_W){imm[`IAC_IMM_MSB]}}, imm};
	assign imm_zx = {{(WIDTH-`IAC_IMM_W){1'b0}}, imm};
	// Lower half forced to zero
	assign imm_up = {imm, {(WIDTH-`IAC_IMM_W){1'b0}}};
	assign opnd_b = !use_imm ? src_b : (upper ? imm_up : (sign_ext ? imm_sx : imm_zx));
endmodule

// file: hdl/iac_top.v
// Summary of operation
// - Second operand is a register or the instruction's 16-bit immediate.
// - Trapping immediate add: sign-extend, add to first source, trap on overflow.
// - Wrapping immediate add: same sum, wraps, never traps.
// - Signed less-than against sign-extended immediate gives 1 or 0.
// - Unsigned less-than against sign-extended immediate gives 1 or 0, no trap.
// - AND, OR, XOR immediate use the zero-extended immediate.
// - Upper load puts immediate in top half, lower half zero.
// - Trapping register add or subtract, trap on signed overflow.
// - Wrapping register add or subtract never traps.
// - Signed less-than of two registers gives 1 or 0.
// - Unsigned less-than of two registers gives 1 or 0.
// - Register AND, OR, XOR, NOR apply bit by bit.
`timescale 1ns/1ns
`include "iac_map.vh"

module iac_top #(
	parameter WIDTH = 32
) (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Issue from decoder
	input wire issue_valid,
	input wire [`IAC_OP_W-1:0] op,
	input wire [1:0] logic_sel,
	input wire [`IAC_DEST_W-1:0] dest_idx,
	input wire [`IAC_IMM_W-1:0] imm,
	// Operands from register file
	input wire [WIDTH-1:0] first_source_reg,
	input wire [WIDTH-1:0] second_source_reg,
	// Writeback to register file
	output reg wr_en,
	output reg [`IAC_DEST_W-1:0] wr_idx,
	output reg [WIDTH-1:0] wr_data,
	// Exception logic
	output reg ovf_trap
);
	// ********************************************
	// Operation decode
	// ********************************************
	reg use_imm;
	reg sign_ext;
	reg upper;
	reg sub;
	reg traps;
	wire [WIDTH-1:0] opnd_b;
	wire [WIDTH-1:0] sum;
	wire ovf;
	wire lt_s;
	wire lt_u;
	reg [WIDTH-1:0] res;

	// Every op spells out all five controls, so a new op cannot quietly
	// inherit a trap or an operand source from the op beside it.
	always @* begin
		case (op)
		`IAC_OP_SUM_IMM_TRAP: begin
			use_imm = 1'b1;
			sign_ext = 1'b1;
			upper = 1'b0;
			sub = 1'b0;
			traps = 1'b1;
		end
		`IAC_OP_SUM_IMM_WRAP: begin
			use_imm = 1'b1;
			sign_ext = 1'b1;
			upper = 1'b0;
			sub = 1'b0;
			traps = 1'b0;
		end
		`IAC_OP_SLT_IMM_S: begin
			use_imm = 1'b1;
			sign_ext = 1'b1;
			upper = 1'b0;
			sub = 1'b0;
			traps = 1'b0;
		end
		`IAC_OP_SLT_IMM_U: begin
			use_imm = 1'b1;
			sign_ext = 1'b1;
			upper = 1'b0;
			sub = 1'b0;
			traps = 1'b0;
		end
		`IAC_OP_AND_IMM: begin
			use_imm = 1'b1;
			sign_ext = 1'b0;
			upper = 1'b0;
			sub = 1'b0;
			traps = 1'b0;
		end
		`IAC_OP_OR_IMM: begin
			use_imm = 1'b1;
			sign_ext = 1'b0;
			upper = 1'b0;
			sub = 1'b0;
			traps = 1'b0;
		end
		`IAC_OP_XOR_IMM: begin
			use_imm = 1'b1;
			sign_ext = 1'b0;
			upper = 1'b0;
			sub = 1'b0;
			traps = 1'b0;
		end
		`IAC_OP_UPPER_IMM: begin
			use_imm = 1'b1;
			sign_ext = 1'b0;
			upper = 1'b1;
			sub = 1'b0;
			traps = 1'b0;
		end
		`IAC_OP_SUM_TRAP: begin
			use_imm = 1'b0;
			sign_ext = 1'b0;
			upper = 1'b0;
			sub = 1'b0;
			traps = 1'b1;
		end
		`IAC_OP_SUM_WRAP: begin
			use_imm = 1'b0;
			sign_ext = 1'b0;
			upper = 1'b0;
			sub = 1'b0;
			traps = 1'b0;
		end
		`IAC_OP_DIFF_TRAP: begin
			use_imm = 1'b0;
			sign_ext = 1'b0;
			upper = 1'b0;
			sub = 1'b1;
			traps = 1'b1;
		end
		`IAC_OP_DIFF_WRAP: begin
			use_imm = 1'b0;
			sign_ext = 1'b0;
			upper = 1'b0;
			sub = 1'b1;
			traps = 1'b0;
		end
		`IAC_OP_SLT_S: begin
			use_imm = 1'b0;
			sign_ext = 1'b0;
			upper = 1'b0;
			sub = 1'b0;
			traps = 1'b0;
		end
		`IAC_OP_SLT_U: begin
			use_imm = 1'b0;
			sign_ext = 1'b0;
			upper = 1'b0;
			sub = 1'b0;
			traps = 1'b0;
		end
		`IAC_OP_AND: begin
			use_imm = 1'b0;
			sign_ext = 1'b0;
			upper = 1'b0;
			sub = 1'b0;
			traps = 1'b0;
		end
		`IAC_OP_NOR_OR_XOR: begin
			use_imm = 1'b0;
			sign_ext = 1'b0;
			upper = 1'b0;
			sub = 1'b0;
			traps = 1'b0;
		end
		default: begin
			use_imm = 1'b0;
			sign_ext = 1'b0;
			upper = 1'b0;
			sub = 1'b0;
			traps = 1'b0;
		end
		endcase
	end

	// ********************************************
	// Operand path and adder
	// ********************************************
	iac_opnd #(
		.WIDTH(WIDTH)
	) u_opnd (
		.use_imm(use_imm),
		.sign_ext(sign_ext),
		.upper(upper),
		.imm(imm),
		.src_b(second_source_reg),
		.opnd_b(opnd_b)
	);

	iac_addsub #(
		.WIDTH(WIDTH)
	) u_addsub (
		.a(first_source_reg),
		.b(opnd_b),
		.sub(sub),
		.sum(sum),
		.ovf(ovf),
		.lt_s(lt_s),
		.lt_u(lt_u)
	);

	// ********************************************
	// Result selection
	// ********************************************
	// The adder output is formed for every op; ovf is only heeded where
	// traps is set, so the wrapping forms share the same adder.
	always @* begin
		case (op)
		`IAC_OP_SUM_IMM_TRAP: begin
			res = sum;
		end
		`IAC_OP_SUM_IMM_WRAP: begin
			res = sum;
		end
		`IAC_OP_SUM_TRAP: begin
			res = sum;
		end
		`IAC_OP_SUM_WRAP: begin
			res = sum;
		end
		`IAC_OP_DIFF_TRAP: begin
			res = sum;
		end
		`IAC_OP_DIFF_WRAP: begin
			res = sum;
		end
		`IAC_OP_SLT_IMM_S: begin
			res = {{(WIDTH-1){1'b0}}, lt_s};
		end
		`IAC_OP_SLT_S: begin
			res = {{(WIDTH-1){1'b0}}, lt_s};
		end
		`IAC_OP_SLT_IMM_U: begin
			res = {{(WIDTH-1){1'b0}}, lt_u};
		end
		`IAC_OP_SLT_U: begin
			res = {{(WIDTH-1){1'b0}}, lt_u};
		end
		`IAC_OP_AND_IMM: begin
			res = first_source_reg & opnd_b;
		end
		`IAC_OP_AND: begin
			res = first_source_reg & opnd_b;
		end
		`IAC_OP_OR_IMM: begin
			res = first_source_reg | opnd_b;
		end
		`IAC_OP_XOR_IMM: begin
			res = first_source_reg ^ opnd_b;
		end
		`IAC_OP_UPPER_IMM: begin
			res = opnd_b;
		end
		`IAC_OP_NOR_OR_XOR: begin
			case (logic_sel)
			`IAC_LSEL_OR: begin
				res = first_source_reg | opnd_b;
			end
			`IAC_LSEL_XOR: begin
				res = first_source_reg ^ opnd_b;
			end
			`IAC_LSEL_NOR: begin
				res = ~(first_source_reg | opnd_b);
			end
			default: begin
				res = ~(first_source_reg | opnd_b);
			end
			endcase
		end
		default: begin
			res = sum;
		end
		endcase
	end

	// ********************************************
	// Writeback register
	// ********************************************
	// One cycle of latency; the trap suppresses the write so the
	// destination keeps its old value.
	always @(posedge clk) begin
		if (!nrst) begin
			wr_en <= 1'b0;
			ovf_trap <= 1'b0;
		end else begin
			wr_en <= issue_valid && !(traps && ovf);
			ovf_trap <= issue_valid && traps && ovf;
		end
	end

	// Index and data hold until the next issue, trapped or not, so the
	// register file side sees steady values between issues.
	always @(posedge clk) begin
		if (!nrst) begin
			wr_idx <= {`IAC_DEST_W{1'b0}};
			wr_data <= `IAC_RESULT_RST;
		end else if (issue_valid) begin
			wr_idx <= dest_idx;
			wr_data <= res;
		end
	end
endmodule

// file: verif/iac_chk.sv
`timescale 1ns/1ns
`include "iac_map.vh"
module iac_chk #(
	parameter WIDTH = 32
) (
	// Clock, reset and issue
	input wire clk,
	input wire nrst,
	input wire issue_valid,
	input wire [`IAC_OP_W-1:0] op,
	input wire [`IAC_IMM_W-1:0] imm,
	input wire [WIDTH-1:0] first_source_reg,
	input wire [WIDTH-1:0] second_source_reg,
	// Writeback and exception
	input wire wr_en,
	input wire [WIDTH-1:0] wr_data,
	input wire ovf_trap
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	excl_out_a: assert property (!(wr_en && ovf_trap)) else $error("write and trap together");
	one_answer_a: assert property (issue_valid |=> wr_en ^ ovf_trap) else $error("no single answer");
	idle_quiet_a: assert property (!issue_valid |=> !wr_en && !ovf_trap) else $error("pulse without issue");
	no_trap_a: assert property (
		issue_valid && !(op inside {`IAC_OP_SUM_IMM_TRAP, `IAC_OP_SUM_TRAP, `IAC_OP_DIFF_TRAP}) |=> !ovf_trap)
		else $error("trap on a non-trapping op");
	upper_imm_a: assert property (
		issue_valid && op == `IAC_OP_UPPER_IMM |=> wr_data == {$past(imm), 16'h0000})
		else $error("upper load word wrong");
	and_imm_a: assert property (issue_valid && op == `IAC_OP_AND_IMM |=>
		wr_data == ($past(first_source_reg) & {16'h0000, $past(imm)})) else $error("and imm wrong");
	wrap_sum_a: assert property (issue_valid && op == `IAC_OP_SUM_WRAP |=>
		wr_data == $past(first_source_reg) + $past(second_source_reg)) else $error("sum wrong");
	slt_sign_a: assert property (issue_valid && op == `IAC_OP_SLT_S |=>
		wr_data == ($signed($past(first_source_reg)) < $signed($past(second_source_reg))))
		else $error("signed compare wrong");
endmodule
bind iac_top iac_chk #(.WIDTH(WIDTH)) u_iac_chk (.clk(clk), .nrst(nrst), .issue_valid(issue_valid), .op(op),
	.imm(imm), .first_source_reg(first_source_reg), .second_source_reg(second_source_reg), .wr_en(wr_en),
	.wr_data(wr_data), .ovf_trap(ovf_trap));

// file: verif/iac_rf.sv
`timescale 1ns/1ns
// Register file behind the writeback port; reads are combinational
module iac_rf (
	// Writeback
	input wire clk,
	input wire wr_en,
	input wire [4:0] wr_idx,
	input wire [31:0] wr_data,
	// Read
	input wire [4:0] rd_idx,
	output wire [31:0] rd_data
);
	logic [31:0] regs_q [0:31];
	always @(posedge clk) begin
		if (wr_en) begin
			regs_q[wr_idx] <= wr_data;
		end
	end
	assign rd_data = regs_q[rd_idx];
endmodule

// file: verif/test_iac_top.sv
`timescale 1ns/1ns
module test_iac_top;
	logic clk = 0, nrst = 0, issue_valid = 0, wr_en, ovf_trap;
	logic [3:0] op = 0;
	logic [1:0] logic_sel = 0;
	logic [15:0] imm = 0;
	logic [31:0] a = 0, b = 0, wr_data, rd_data;
	logic [4:0] wr_idx, dest = 5'h03;
	int errors = 0, n_compared = 0, cycles = 0;
	iac_top u_iac_top (.clk(clk), .nrst(nrst), .issue_valid(issue_valid), .op(op), .logic_sel(logic_sel),
		.dest_idx(dest), .imm(imm), .first_source_reg(a), .second_source_reg(b), .wr_en(wr_en),
		.wr_idx(wr_idx), .wr_data(wr_data), .ovf_trap(ovf_trap));
	iac_rf u_iac_rf (.clk(clk), .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data), .rd_idx(5'h03), .rd_data(rd_data));
	initial forever #4 clk = ~clk;
	// Ops are short, so a few hundred cycles means a hang
	always @(posedge clk) begin
		cycles++;
		if (cycles == 500) begin
			errors++;
			wrap_up();
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// s holds {logic_sel, op}; issue stays up so ops go back to back
	task run(input logic [5:0] s, input logic [15:0] i, input logic [31:0] x, y, exp, input logic en);
		{logic_sel, op} = s;
		imm = i;
		a = x;
		b = y;
		issue_valid = 1;
		@(posedge clk) #1;
		chk({wr_en, ovf_trap}, {en, ~en});
		chk(wr_idx, dest);
		if (en) chk(wr_data, exp);
	endtask
	task idle;
		issue_valid = 0;
		@(posedge clk) #1;
		chk({wr_en, ovf_trap}, 32'h0);
	endtask
	task t_imm;
		run(6'h00, 16'h0001, 32'h7FFFFFFF, 32'h0, 32'h0, 0);
		run(6'h00, 16'hFFFF, 32'h5, 32'h0, 32'h4, 1);
		run(6'h02, 16'h0001, 32'h5, 32'h0, 32'h0, 1);
		run(6'h01, 16'hFFFF, 32'h80000000, 32'h0, 32'h7FFFFFFF, 1);
		run(6'h02, 16'hFFFF, 32'hFFFFFFFE, 32'h0, 32'h1, 1);
		run(6'h03, 16'hFFFF, 32'h7, 32'h0, 32'h1, 1);
		run(6'h04, 16'hFFFF, 32'hF0F0F0F0, 32'h0, 32'h0000F0F0, 1);
		run(6'h06, 16'hFFFF, 32'hF0F0F0F0, 32'h0, 32'hF0F00F0F, 1);
		run(6'h05, 16'hFFFF, 32'hF0F0F0F0, 32'h0, 32'hF0F0FFFF, 1);
		run(6'h07, 16'h8001, 32'h0, 32'h0, 32'h80010000, 1);
		idle();
		$display("t_imm done");
	endtask
	task t_reg;
		dest = 5'h1C;
		run(6'h0A, 16'h0, 32'h80000000, 32'h1, 32'h0, 0);
		run(6'h0A, 16'h0, 32'h5, 32'h7, 32'hFFFFFFFE, 1);
		run(6'h08, 16'h0, 32'h80000000, 32'h1, 32'h80000001, 1);
		run(6'h0E, 16'h0, 32'hF0F0F0F0, 32'hFF00FF00, 32'hF000F000, 1);
		run(6'h0F, 16'h0, 32'hF0F0F0F0, 32'hFF00FF00, 32'hFFF0FFF0, 1);
		run(6'h3F, 16'h0, 32'hF0F0F0F0, 32'hFF00FF00, 32'h000F000F, 1);
		run(6'h0B, 16'h0, 32'h80000000, 32'h1, 32'h7FFFFFFF, 1);
		run(6'h0C, 16'h0, 32'h80000000, 32'h1, 32'h1, 1);
		run(6'h0D, 16'h0, 32'h80000000, 32'h1, 32'h0, 1);
		run(6'h2F, 16'h0, 32'hF0F0F0F0, 32'hFF00FF00, 32'h000F000F, 1);
		run(6'h1F, 16'h0, 32'hF0F0F0F0, 32'hFF00FF00, 32'h0FF00FF0, 1);
		idle();
		$display("t_reg done");
	endtask
	task t_trap;
		dest = 5'h03;
		run(6'h09, 16'h0, 32'h1, 32'h2, 32'h3, 1);
		run(6'h08, 16'h0, 32'h7FFFFFFF, 32'h1, 32'h0, 0);
		idle();
		chk(rd_data, 32'h3);
		$display("t_trap done");
	endtask
	task wrap_up;
		$display("Compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		#1;
		nrst = 1;
		chk({wr_en, ovf_trap}, 32'h0);
		t_imm();
		t_reg();
		t_trap();
		wrap_up();
	end
endmodule
